// [ivp_pkg.sv]
// constants and types of the vectored interrupt prioritizer
package ivp_pkg;
  localparam int IVP_SLOTS = 24;
  localparam int IVP_AW = 8;
  // register byte offsets
  localparam logic [7:0] IVP_OFS_PEND = 8'h00;
  localparam logic [7:0] IVP_OFS_PRIO_LO = 8'h04;
  localparam logic [7:0] IVP_OFS_PRIO_HI = 8'h08;
  localparam logic [7:0] IVP_OFS_CTRL = 8'h0c;
  localparam logic [7:0] IVP_OFS_EDGE = 8'h10;
  localparam logic [7:0] IVP_OFS_SRC = 8'h14;
  localparam logic [7:0] IVP_OFS_STAT = 8'h18;
  // control bit positions
  localparam int IVP_CTRL_GE = 0;
  localparam int IVP_CTRL_WDT_IRQ = 1;
  // status field positions
  localparam int IVP_STAT_LVL = 16;
  localparam int IVP_STAT_KIND = 18;
  localparam int IVP_STAT_VALID = 31;
  // vector addresses
  localparam logic [15:0] IVP_VEC_RESET = 16'h0002;
  localparam logic [15:0] IVP_VEC_WDT = 16'h0004;
  localparam logic [15:0] IVP_VEC_ILL = 16'h0006;
  localparam logic [15:0] IVP_VEC_OSC = 16'h003a;
  localparam logic [15:0] IVP_VEC_WOSC = 16'h003c;
  localparam logic [15:0] IVP_VEC_BASE = 16'h0008;
  localparam logic [15:0] IVP_VEC_RSVD_A = 16'h0028;
  localparam logic [15:0] IVP_VEC_RSVD_B = 16'h0038;
  // slot positions
  localparam int IVP_SLOT_ADC = 7;
  localparam int IVP_SLOT_RSVD = 16;
  // reset values and top priority level
  localparam logic [23:0] IVP_RST_PEND = 24'h000000;
  localparam logic [23:0] IVP_RST_PRIO = 24'h000000;
  localparam logic [11:0] IVP_RST_EDGE = 12'h000;
  localparam logic [6:0] IVP_RST_SRC = 7'h00;
  localparam logic [1:0] IVP_LVL_TOP = 2'h3;
  typedef enum logic [2:0] {
    IVP_K_SLOT = 3'b000,
    IVP_K_RESET = 3'b001,
    IVP_K_WDT = 3'b010,
    IVP_K_OSC = 3'b011,
    IVP_K_WOSC = 3'b100,
    IVP_K_ILL = 3'b101
  } ivp_kind_e;
endpackage

// [ivp_prioritizer.sv]
// vectored interrupt prioritizer with apb register access
// How it works
// [RULE_01] arbitrate peripheral and port pin requests, pick one for service
// [RULE_02] thirty-one sources fold onto twenty-four vectors
// [RULE_03] sixteen port pin sources, seven port vectors shared
// [RULE_04] fifteen peripheral sources, three vectors shared port/peripheral
// [RULE_05] twelve port sources trigger on a per-source chosen edge
// [RULE_06] port c pins 0-3 fire on both edges, vectors 0x30-0x36
// [RULE_07] every source has its own three-level priority
// [RULE_08] watchdog may interrupt instead of reset, vector 0x0004
// [RULE_09] polled handling is untouched by arbitration and vectoring
// [RULE_10] cpu fetches vector high byte at even, low at odd address
// [RULE_11] reset ranks first, vector 0x0002, not an interrupt
// [RULE_12] oscillator, watchdog oscillator, illegal instruction traps follow watchdog
// [RULE_13] fixed table order in a level, vectors rising by two
// [RULE_14] vector 0x18 serves port a7 or low voltage detector
// [RULE_15] 0x1a port a6 or comparator 0, 0x1c a5 or comparator 1
// [RULE_16] 0x1e-0x24 shared between port a n and port d n
// [RULE_17] table order only breaks ties within one level
// [RULE_18] without converter its source is absent and never set
// [RULE_19] service suspends program orderly, return resumes it
// [RULE_20] level 3 beats 2 beats 1; reset, watchdog, traps at 3
// [RULE_21] one-cycle source pulse sets the pending bit
// [RULE_22] acknowledge or write 0 clears pending, write 1 raises request
// [RULE_23] global enable set by ei, irq_return_instruction, write 1; cleared otherwise
// [RULE_24] present winner vector while enabled, hold until acknowledge
// [RULE_25] reserved slots 0x28 and 0x38 never selected
//
// The register offsets and register access over APB are this design's own decisions.
module ivp_prioritizer
  import ivp_pkg::*;
#(
  parameter bit HAS_ADC = 1'b1
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IVP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral request pulses
  input wire logic irq_timer2,
  input wire logic irq_timer1,
  input wire logic irq_timer0,
  input wire logic irq_uart0_rx,
  input wire logic irq_uart0_tx,
  input wire logic irq_i2c,
  input wire logic irq_spi,
  input wire logic irq_adc,
  input wire logic irq_low_voltage_detector,
  input wire logic irq_cmp0,
  input wire logic irq_cmp1,
  input wire logic irq_mct,
  input wire logic irq_uart1_rx,
  input wire logic irq_uart1_tx,
  input wire logic irq_watchdog_timer,
  // trap pulses
  input wire logic trap_osc_fail,
  input wire logic trap_wdt_osc_fail,
  input wire logic trap_illegal,
  input wire logic trap_instruction,
  // port pins, asynchronous
  input wire logic [7:0] port_a,
  input wire logic [4:1] port_d,
  input wire logic [3:0] port_c,
  // cpu side
  input wire logic cpu_ack,
  input wire logic enable_irq_instruction,
  input wire logic disable_irq_instruction,
  input wire logic irq_return_instruction,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic [1:0] vec_level
);

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] prev;
    logic [2:0] warm;
    logic [23:0] pend;
    logic [23:0] prio_lo;
    logic [23:0] prio_hi;
    logic [11:0] edge_sel;
    logic [6:0] src_sel;
    logic wdt_irq;
    logic ge;
    logic reset_pend;
    logic wdt_pend;
    logic osc_pend;
    logic wosc_pend;
    logic ill_pend;
    logic vec_valid;
    logic [15:0] vec_addr;
    logic [1:0] vec_level;
    ivp_kind_e kind;
    logic [4:0] sel_idx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ivp_state_s;

  ivp_state_s st;
  ivp_state_s n;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [11:0] sel_ev;
  logic [3:0] both_ev;
  logic [23:0] hw_set;
  logic [23:0] slot_mask;
  logic [1:0] win_lvl;
  logic [4:0] win_idx;
  logic [1:0] max_lvl;
  logic wr;
  logic hit;
  logic [31:0] rd;

  always_comb begin
    n = st;
    rd = 32'h00000000;
    hit = 1'b1;
    win_lvl = 2'h0;
    win_idx = 5'h00;
    max_lvl = 2'h0;
    // two-stage pin synchroniser, then edge history
    n.sync1 = {port_c, port_d, port_a};
    n.sync2 = st.sync1;
    n.prev = st.sync2;
    // no edges until the history holds real pin samples
    n.warm = {st.warm[1:0], 1'b1};
    rise = st.sync2 & ~st.prev & {16{st.warm[2]}};
    fall = ~st.sync2 & st.prev & {16{st.warm[2]}};
    // [RULE_05] selectable edge, 1 picks falling
    sel_ev = (rise[11:0] & ~st.edge_sel) | (fall[11:0] & st.edge_sel);
    // [RULE_06] port c both edges
    both_ev = rise[15:12] | fall[15:12];
    // [RULE_25] reserved slot never drivable
    slot_mask = 24'hffffff;
    slot_mask[IVP_SLOT_RSVD] = 1'b0;
    // [RULE_18] converter absent
    slot_mask[IVP_SLOT_ADC] = HAS_ADC;
    // [RULE_02] source to vector folding
    hw_set = 24'h000000;
    // [RULE_04] peripheral sources
    hw_set[0] = irq_timer2;
    hw_set[1] = irq_timer1;
    hw_set[2] = irq_timer0;
    hw_set[3] = irq_uart0_rx;
    hw_set[4] = irq_uart0_tx;
    hw_set[5] = irq_i2c;
    hw_set[6] = irq_spi;
    hw_set[7] = irq_adc;
    // [RULE_14] port a7 or low voltage
    hw_set[8] = st.src_sel[0] ? irq_low_voltage_detector : sel_ev[7];
    // [RULE_15] port a6/a5 or comparators
    hw_set[9] = st.src_sel[1] ? irq_cmp0 : sel_ev[6];
    hw_set[10] = st.src_sel[2] ? irq_cmp1 : sel_ev[5];
    // [RULE_16] port a n or port d n
    for (int k = 0; k < 4; k++) begin
      hw_set[11+k] = st.src_sel[3+k] ? sel_ev[11-k] : sel_ev[4-k];
    end
    // [RULE_03] remaining port sources, plus the mct and uart1 peripheral sources
    hw_set[15] = sel_ev[0];
    hw_set[17] = irq_mct;
    hw_set[18] = irq_uart1_rx;
    hw_set[19] = irq_uart1_tx;
    for (int k = 0; k < 4; k++) begin
      hw_set[20+k] = both_ev[3-k];
    end
    hw_set = hw_set & slot_mask;
    // [RULE_01] pick one pending request
    // [RULE_17] level first, lower slot wins ties
    for (int k = IVP_SLOTS - 1; k >= 0; k--) begin
      if (st.pend[k] && slot_mask[k] && ({st.prio_hi[k], st.prio_lo[k]} != 2'h0)
          && ({st.prio_hi[k], st.prio_lo[k]} >= win_lvl)) begin
        win_lvl = {st.prio_hi[k], st.prio_lo[k]};
        win_idx = 5'(k);
      end
    end
    for (int k = 0; k < IVP_SLOTS; k++) begin
      if (st.pend[k] && slot_mask[k] && ({st.prio_hi[k], st.prio_lo[k]} > max_lvl)) begin
        max_lvl = {st.prio_hi[k], st.prio_lo[k]};
      end
    end
    // apb read mux, unmapped answers error
    case (paddr)
      IVP_OFS_PEND: rd = {8'h00, st.pend};
      IVP_OFS_PRIO_LO: rd = {8'h00, st.prio_lo};
      IVP_OFS_PRIO_HI: rd = {8'h00, st.prio_hi};
      IVP_OFS_CTRL: rd = {30'h00000000, st.wdt_irq, st.ge};
      IVP_OFS_EDGE: rd = {20'h00000, st.edge_sel};
      IVP_OFS_SRC: rd = {25'h0000000, st.src_sel};
      IVP_OFS_STAT: begin
        rd = {16'h0000, st.vec_addr};
        rd[IVP_STAT_LVL+:2] = st.vec_level;
        rd[IVP_STAT_KIND+:3] = st.kind;
        rd[IVP_STAT_VALID] = st.vec_valid;
      end
      default: hit = 1'b0;
    endcase
    n.pready = psel && !penable && !st.pready;
    if (psel && !penable) begin
      n.prdata = pwrite ? 32'h00000000 : rd;
      n.pslverr = !hit;
    end
    wr = psel && penable && st.pready && pwrite;
    if (wr) begin
      case (paddr)
        // [RULE_07] per-source level bits
        IVP_OFS_PRIO_LO: n.prio_lo = pwdata[23:0];
        IVP_OFS_PRIO_HI: n.prio_hi = pwdata[23:0];
        IVP_OFS_EDGE: n.edge_sel = pwdata[11:0];
        IVP_OFS_SRC: n.src_sel = pwdata[6:0];
        IVP_OFS_CTRL: n.wdt_irq = pwdata[IVP_CTRL_WDT_IRQ];
        default: n.wdt_irq = st.wdt_irq;
      endcase
    end
    // [RULE_19] acknowledge enters the handler
    // [RULE_22] acknowledge clears presented pending bit
    if (cpu_ack && st.vec_valid) begin
      case (st.kind)
        IVP_K_SLOT: n.pend[st.sel_idx] = 1'b0;
        IVP_K_RESET: n.reset_pend = 1'b0;
        IVP_K_WDT: n.wdt_pend = 1'b0;
        IVP_K_OSC: n.osc_pend = 1'b0;
        IVP_K_WOSC: n.wosc_pend = 1'b0;
        IVP_K_ILL: n.ill_pend = 1'b0;
        default: n.reset_pend = st.reset_pend;
      endcase
    end
    // [RULE_22] software write sets or clears pending
    if (wr && paddr == IVP_OFS_PEND) begin
      n.pend = pwdata[23:0] & slot_mask;
    end
    // [RULE_21] source pulse sets pending, winning over clear
    n.pend = n.pend | hw_set;
    // [RULE_08] watchdog as interrupt
    if (irq_watchdog_timer && st.wdt_irq) begin
      n.wdt_pend = 1'b1;
    end
    // [RULE_12] trap pending flags
    if (trap_osc_fail) begin
      n.osc_pend = 1'b1;
    end
    if (trap_wdt_osc_fail) begin
      n.wosc_pend = 1'b1;
    end
    if (trap_illegal) begin
      n.ill_pend = 1'b1;
    end
    // [RULE_23] global enable set then clear events
    if (enable_irq_instruction || irq_return_instruction
        || (wr && paddr == IVP_OFS_CTRL && pwdata[IVP_CTRL_GE])) begin
      n.ge = 1'b1;
    end
    if (disable_irq_instruction || (cpu_ack && st.vec_valid) || trap_instruction
        || trap_osc_fail || trap_wdt_osc_fail || trap_illegal
        || (wr && paddr == IVP_OFS_CTRL && !pwdata[IVP_CTRL_GE])) begin
      n.ge = 1'b0;
    end
    // [RULE_24] present and hold until acknowledge
    if (cpu_ack && st.vec_valid) begin
      n.vec_valid = 1'b0;
    end else if (!st.vec_valid) begin
      n.vec_level = IVP_LVL_TOP;
      // [RULE_11] reset first
      if (st.reset_pend) begin
        n.vec_valid = 1'b1;
        n.kind = IVP_K_RESET;
        n.vec_addr = IVP_VEC_RESET;
      // [RULE_20] watchdog and traps above all levels
      end else if (st.wdt_pend && st.ge) begin
        n.vec_valid = 1'b1;
        n.kind = IVP_K_WDT;
        n.vec_addr = IVP_VEC_WDT;
      end else if (st.osc_pend) begin
        n.vec_valid = 1'b1;
        n.kind = IVP_K_OSC;
        n.vec_addr = IVP_VEC_OSC;
      end else if (st.wosc_pend) begin
        n.vec_valid = 1'b1;
        n.kind = IVP_K_WOSC;
        n.vec_addr = IVP_VEC_WOSC;
      end else if (st.ill_pend) begin
        n.vec_valid = 1'b1;
        n.kind = IVP_K_ILL;
        n.vec_addr = IVP_VEC_ILL;
      // [RULE_09] slot delivery gated by global enable
      end else if (st.ge && win_lvl != 2'h0) begin
        // [RULE_13] vector rises by two per slot
        n.vec_valid = 1'b1;
        n.kind = IVP_K_SLOT;
        n.sel_idx = win_idx;
        n.vec_level = win_lvl;
        n.vec_addr = IVP_VEC_BASE + {10'h000, win_idx, 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.reset_pend <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign vec_valid = st.vec_valid;
  assign vec_addr = st.vec_addr;
  assign vec_level = st.vec_level;

  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_24
    st.vec_valid && !cpu_ack |=> st.vec_valid && $stable(st.vec_addr))
    else $error("presented vector not held");
  AST_ACK_DROP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
    st.vec_valid && cpu_ack && !enable_irq_instruction && !irq_return_instruction
    |=> !st.vec_valid && !st.ge)
    else $error("acknowledge did not drop vector and enable");
  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_25
    st.vec_valid |-> st.vec_addr != IVP_VEC_RSVD_A && st.vec_addr != IVP_VEC_RSVD_B)
    else $error("reserved vector presented");
  AST_NOADC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    !HAS_ADC |-> !st.pend[IVP_SLOT_ADC])
    else $error("absent converter request pending");
  AST_PULSE_SET: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
    hw_set != 24'h000000 |=> (st.pend & $past(hw_set)) == $past(hw_set))
    else $error("source pulse lost");
  AST_GATE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    !st.vec_valid && !st.ge && !st.reset_pend && !st.osc_pend && !st.wosc_pend
    && !st.ill_pend |=> !st.vec_valid)
    else $error("vector delivered while disabled");
  AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
    $rose(st.vec_valid) && st.kind == IVP_K_SLOT |-> st.vec_level == $past(max_lvl))
    else $error("lower level won arbitration");
  AST_RESET_VEC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    st.vec_valid && st.kind == IVP_K_RESET |-> st.vec_addr == IVP_VEC_RESET)
    else $error("wrong reset vector");
  AST_TRAP_GE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    trap_osc_fail || trap_illegal
    |=> !st.ge && (st.osc_pend || st.ill_pend) ##1 (st.vec_valid || $past(cpu_ack)))
    else $error("trap left enable set or not presented");
  AST_VEC_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    st.vec_valid && st.kind == IVP_K_SLOT
    |-> st.vec_addr == IVP_VEC_BASE + {10'h000, st.sel_idx, 1'b0})
    else $error("slot vector address wrong");
  AST_TOP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
    st.vec_valid && st.kind != IVP_K_SLOT |-> st.vec_level == IVP_LVL_TOP)
    else $error("fixed entry below top level");
  AST_SLOT_GE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_24
    $rose(st.vec_valid) && st.kind == IVP_K_SLOT |-> $past(st.ge))
    else $error("slot vector raised while disabled");
  AST_RESET_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    $rose(st.vec_valid) && $past(st.reset_pend) |-> st.kind == IVP_K_RESET)
    else $error("reset entry lost precedence");
  AST_C_EDGES: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    st.warm[2] && st.sync2[12] != st.prev[12] |=> st.pend[23])
    else $error("port c0 edge not latched");
  AST_TRAP_VEC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    st.vec_valid |-> (st.kind != IVP_K_OSC || st.vec_addr == IVP_VEC_OSC)
    && (st.kind != IVP_K_WOSC || st.vec_addr == IVP_VEC_WOSC)
    && (st.kind != IVP_K_ILL || st.vec_addr == IVP_VEC_ILL))
    else $error("trap vector address wrong");
  AST_WDT_VEC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    st.vec_valid && st.kind == IVP_K_WDT |-> st.vec_addr == IVP_VEC_WDT)
    else $error("watchdog vector address wrong");

endmodule

// [ivp_cpu_model.sv]
// processor core model that takes vectors from the prioritizer
module ivp_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // vector side
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  input wire logic [1:0] vec_level,
  input wire logic slow,
  output logic cpu_ack,
  // what was taken
  output logic [15:0] fetched,
  output logic [1:0] got_level,
  output int n_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  logic busy;
  // program memory: handler page at even byte, low byte at odd byte
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[0] ? {a[7:1], 1'b0} : 8'h10 | a[15:8];
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      wait_cnt <= '0;
      busy <= 1'b0;
      fetched <= '0;
      got_level <= '0;
      n_taken <= 0;
    end else begin
      cpu_ack <= 1'b0;
      if (!vec_valid) begin
        busy <= 1'b0;
      end else if (!busy && wait_cnt != (slow ? 3'h4 : 3'h0)) begin
        wait_cnt <= wait_cnt + 3'h1;
      end else if (!busy) begin
        // high byte even, low byte odd
        fetched <= {mem_byte(vec_addr), mem_byte(vec_addr | 16'h0001)};
        got_level <= vec_level;
        cpu_ack <= 1'b1;
        busy <= 1'b1;
        wait_cnt <= '0;
        n_taken <= n_taken + 1;
      end
    end
  end
endmodule

// [vectored_interrupt_prioritizer_test.sv]
// self-checking bench of the vectored interrupt prioritizer
module vectored_interrupt_prioritizer_test import ivp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdt = 1'b0, slow = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cpu_ack, vec_valid;
  logic [23:0] pul = '0;
  logic [2:0] trp = '0;
  logic [3:0] ins = '0;
  logic [7:0] pa = '0;
  logic [4:1] pd = '0;
  logic [3:0] pc = '0;
  logic [15:0] vec_addr, fetched;
  logic [1:0] vec_level, got_level;
  logic [23:0] pm, lo, hi;
  int n_errors = 0, comparisons = 0, n_taken, n0 = 0, w;
  ivp_prioritizer u_ivp_prioritizer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_timer2(pul[0]), .irq_timer1(pul[1]), .irq_timer0(pul[2]), .irq_uart0_rx(pul[3]),
    .irq_uart0_tx(pul[4]), .irq_i2c(pul[5]), .irq_spi(pul[6]), .irq_adc(pul[7]),
    .irq_low_voltage_detector(pul[8]), .irq_cmp0(pul[9]), .irq_cmp1(pul[10]),
    .irq_mct(pul[17]), .irq_uart1_rx(pul[18]), .irq_uart1_tx(pul[19]),
    .irq_watchdog_timer(wdt), .trap_osc_fail(trp[0]), .trap_wdt_osc_fail(trp[1]),
    .trap_illegal(trp[2]), .trap_instruction(ins[3]), .port_a(pa), .port_d(pd), .port_c(pc),
    .cpu_ack(cpu_ack), .enable_irq_instruction(ins[0]), .disable_irq_instruction(ins[1]),
    .irq_return_instruction(ins[2]), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .vec_level(vec_level)
  );
  // converter-less variant, watched by its own assertions
  ivp_prioritizer #(
    .HAS_ADC(1'b0)
  ) u_ivp_prioritizer_noadc (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .irq_timer2(pul[0]), .irq_timer1(pul[1]), .irq_timer0(pul[2]), .irq_uart0_rx(pul[3]),
    .irq_uart0_tx(pul[4]), .irq_i2c(pul[5]), .irq_spi(pul[6]), .irq_adc(pul[7]),
    .irq_low_voltage_detector(pul[8]), .irq_cmp0(pul[9]), .irq_cmp1(pul[10]),
    .irq_mct(pul[17]), .irq_uart1_rx(pul[18]), .irq_uart1_tx(pul[19]),
    .irq_watchdog_timer(wdt), .trap_osc_fail(trp[0]), .trap_wdt_osc_fail(trp[1]),
    .trap_illegal(trp[2]), .trap_instruction(ins[3]), .port_a(pa), .port_d(pd), .port_c(pc),
    .cpu_ack(cpu_ack), .enable_irq_instruction(ins[0]), .disable_irq_instruction(ins[1]),
    .irq_return_instruction(ins[2]), .vec_valid(), .vec_addr(), .vec_level()
  );
  ivp_cpu_model u_ivp_cpu_model (
    .pclk(pclk), .presetn(presetn), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .vec_level(vec_level), .slow(slow), .cpu_ack(cpu_ack), .fetched(fetched),
    .got_level(got_level), .n_taken(n_taken)
  );
  always #20 pclk = ~pclk;
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic take(input logic [15:0] e, input logic [1:0] l);
    int n;
    n = 0;
    while (n_taken == n0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) n_errors++;
    chk({16'h0, fetched}, {24'h10, e[7:0]});
    chk({30'h0, got_level}, {30'h0, l});
    n0 = n_taken;
    @(posedge pclk);
  endtask
  function automatic int winner(input logic [23:0] p, input logic [23:0] l, input logic [23:0] h);
    int r, best;
    r = -1;
    best = 0;
    for (int i = 0; i < 24; i++) begin
      if (p[i] && int'({h[i], l[i]}) > best) begin
        r = i;
        best = int'({h[i], l[i]});
      end
    end
    return r;
  endfunction
  initial begin
    void'($urandom(26331));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    take(IVP_VEC_RESET, IVP_LVL_TOP);
    for (int a = 0; a < 24; a += 4) rdc(8'(a), 32'hffffffff, 32'h0);
    rdc(8'h1c, 32'hffffffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, IVP_OFS_CTRL, {31'h0, k[0]});
      ins <= 4'h1 << k;
      @(posedge pclk);
      ins <= '0;
      rdc(IVP_OFS_CTRL, 32'h1, {31'h0, ~k[0]});
    end
    for (int t = 0; t < 30; t++) begin
      slow <= 1'($urandom_range(0, 1));
      pm = 24'($urandom()) & 24'h0e07ff;
      lo = 24'($urandom());
      hi = 24'($urandom());
      if (t == 0) begin
        pm = 24'h0c0000;
        lo = '1;
        hi = '1;
      end
      if (winner(pm, lo, hi) < 0) begin
        pm[0] = 1'b1;
        lo[0] = 1'b1;
      end
      w = winner(pm, lo, hi);
      apb(1'b1, IVP_OFS_CTRL, 32'h0);
      apb(1'b1, IVP_OFS_PRIO_LO, {8'h0, lo});
      apb(1'b1, IVP_OFS_PRIO_HI, {8'h0, hi});
      apb(1'b1, IVP_OFS_SRC, 32'h7);
      pul <= pm;
      @(posedge pclk);
      pul <= '0;
      rdc(IVP_OFS_PEND, 32'hffffff, {8'h0, pm});
      chk({31'h0, vec_valid}, 32'h0);
      apb(1'b1, IVP_OFS_CTRL, 32'h1);
      take(IVP_VEC_BASE + 16'(2 * w), {hi[w], lo[w]});
      pm[w] = 1'b0;
      rdc(IVP_OFS_PEND, 32'hffffff, {8'h0, pm});
      rdc(IVP_OFS_CTRL, 32'h1, 32'h0);
      apb(1'b1, IVP_OFS_PEND, 32'h0);
    end
    apb(1'b1, IVP_OFS_PEND, 32'hffffff);
    rdc(IVP_OFS_PEND, 32'hffffff, 32'hfeffff);
    apb(1'b1, IVP_OFS_PEND, 32'h020000);
    apb(1'b1, IVP_OFS_PRIO_LO, 32'h020001);
    apb(1'b1, IVP_OFS_PRIO_HI, 32'h1);
    apb(1'b1, IVP_OFS_CTRL, 32'h1);
    take(16'h002a, 2'h1);
    apb(1'b1, IVP_OFS_CTRL, 32'h3);
    wdt <= 1'b1;
    pul <= 24'h1;
    @(posedge pclk);
    wdt <= 1'b0;
    pul <= '0;
    take(IVP_VEC_WDT, IVP_LVL_TOP);
    rdc(IVP_OFS_STAT, 32'hffffffff, {11'h0, 3'(IVP_K_WDT), IVP_LVL_TOP, IVP_VEC_WDT});
    apb(1'b1, IVP_OFS_CTRL, 32'h1);
    take(IVP_VEC_BASE, IVP_LVL_TOP);
    trp <= 3'h7;
    @(posedge pclk);
    trp <= '0;
    take(IVP_VEC_OSC, IVP_LVL_TOP);
    take(IVP_VEC_WOSC, IVP_LVL_TOP);
    take(IVP_VEC_ILL, IVP_LVL_TOP);
    apb(1'b1, IVP_OFS_SRC, 32'h0);
    apb(1'b1, IVP_OFS_EDGE, 32'h2);
    apb(1'b1, IVP_OFS_PRIO_LO, 32'h800000);
    pa <= 8'h03;
    pc <= 4'h1;
    repeat (6) @(posedge pclk);
    rdc(IVP_OFS_PEND, 32'hffffff, 32'h808000);
    apb(1'b1, IVP_OFS_CTRL, 32'h1);
    take(16'h0036, 2'h1);
    apb(1'b1, IVP_OFS_PEND, 32'h0);
    pa <= 8'h00;
    pc <= 4'h0;
    repeat (6) @(posedge pclk);
    rdc(IVP_OFS_PEND, 32'hffffff, 32'h804000);
    apb(1'b1, IVP_OFS_PEND, 32'h0);
    apb(1'b1, IVP_OFS_SRC, 32'h40);
    pd <= 4'h1;
    repeat (6) @(posedge pclk);
    rdc(IVP_OFS_PEND, 32'hffffff, 32'h004000);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done;
  end
endmodule
